// File: rtl/halt_trap_and_clock_out_ctrl.sv
`timescale 1ns/1ps
`include "halt_trap_consts.svh"
module halt_trap_and_clock_out_ctrl
	import halt_trap_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    clk_en,
	// CPU events
	input  wire logic                    halt_exec,
	input  wire logic                    cancel_req,
	input  wire logic                    trap_en_wr,
	input  wire logic                    trap_en_wdata,
	// Clock-out control bits
	input  wire logic                    clock_out_stop,
	input  wire logic                    clock_out_select,
	input  wire logic                    pin_dir,
	input  wire logic                    bus_cycle_end,
	input  wire logic                    bus_clk_level,
	// Standby modes and general port
	input  wire logic                    sw_standby,
	input  wire logic                    hw_standby,
	input  wire logic [`PORT_WIDTH-1:0]  port_out,
	input  wire logic [`PORT_WIDTH-1:0]  port_dir,
	// Outputs
	output logic                         halt_trap_enable,
	output logic                         power_down,
	output logic                         halt_exc_start,
	output logic                         cancel_exc_start,
	output logic                         clk_pin_o,
	output logic                         clk_pin_oe,
	output logic                         clk_setting_bad,
	output logic [`PORT_WIDTH-1:0]       port_pin_o,
	output logic [`PORT_WIDTH-1:0]       port_pin_oe
);

	//----------------------------------------
	// Halt / power-down sequencing
	//----------------------------------------
	cpu_state_e st_ff, nxt_st;
	logic       trap_ff, nxt_trap;
	logic       hexc_ff, nxt_hexc;
	logic       cexc_ff, nxt_cexc;
	logic       pd_ff, nxt_pd;

	// A cancel arriving with the halt is serviced first; power-down follows only with the trap disabled
	always_comb begin
		nxt_st   = st_ff;
		nxt_trap = trap_en_wr ? trap_en_wdata : trap_ff;
		nxt_hexc = 1'b0;
		nxt_cexc = 1'b0;
		unique case (st_ff)
			ST_RUN: begin
				if (cancel_req)
					nxt_cexc = 1'b1;
				if (halt_exec)
					nxt_st = ST_HALT;
			end
			ST_HALT: begin
				if (trap_ff) begin
					nxt_hexc = 1'b1;
					nxt_st   = ST_RUN;
				end else begin
					nxt_st = ST_DOWN;
				end
			end
			ST_DOWN: begin
				if (cancel_req)
					nxt_st = ST_WAKE;
			end
			ST_WAKE: begin
				nxt_cexc = 1'b1;
				nxt_st   = ST_RUN;
			end
		endcase
		nxt_pd = (nxt_st == ST_DOWN);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff   <= ST_RUN;
			trap_ff <= `HALT_TRAP_ENABLE_RST;
			hexc_ff <= `FLAG_RST;
			cexc_ff <= `FLAG_RST;
			pd_ff   <= `FLAG_RST;
		end else if (clk_en) begin
			st_ff   <= nxt_st;
			trap_ff <= nxt_trap;
			hexc_ff <= nxt_hexc;
			cexc_ff <= nxt_cexc;
			pd_ff   <= nxt_pd;
		end
	end

	assign halt_trap_enable = trap_ff;
	assign power_down       = pd_ff;
	assign halt_exc_start   = hexc_ff;
	assign cancel_exc_start = cexc_ff;

	//----------------------------------------
	// Clock output pin
	//----------------------------------------
	logic stopped_ff, nxt_stopped;
	logic po_ff, nxt_po;
	logic poe_ff, nxt_poe;
	logic bad_ff, nxt_bad;

	// Stop only takes hold at a bus cycle boundary to avoid a runt pulse
	always_comb begin
		nxt_stopped = stopped_ff;
		if (!clock_out_stop)
			nxt_stopped = 1'b0;
		else if (bus_cycle_end)
			nxt_stopped = 1'b1;
		nxt_bad = pin_dir && !clock_out_stop && clock_out_select;
		nxt_poe = pin_dir && !hw_standby;
		if (stopped_ff || sw_standby || nxt_bad)
			nxt_po = `CLK_PIN_HIGH;
		else
			nxt_po = bus_clk_level;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stopped_ff <= `FLAG_RST;
			po_ff      <= `CLK_PIN_HIGH;
			poe_ff     <= `FLAG_RST;
			bad_ff     <= `FLAG_RST;
		end else if (clk_en) begin
			stopped_ff <= nxt_stopped;
			po_ff      <= nxt_po;
			poe_ff     <= nxt_poe;
			bad_ff     <= nxt_bad;
		end
	end

	assign clk_pin_o       = po_ff;
	assign clk_pin_oe      = poe_ff;
	assign clk_setting_bad = bad_ff;

	//----------------------------------------
	// General port hold in software standby
	//----------------------------------------
	logic [`PORT_WIDTH-1:0] pdat_ff, nxt_pdat;
	logic [`PORT_WIDTH-1:0] pdir_ff, nxt_pdir;

	// Held levels keep driving, so software standby does not save output current
	always_comb begin
		nxt_pdat = sw_standby ? pdat_ff : port_out;
		nxt_pdir = hw_standby ? {`PORT_WIDTH{1'b0}} : (sw_standby ? pdir_ff : port_dir);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pdat_ff <= `PORT_RST;
			pdir_ff <= `PORT_RST;
		end else if (clk_en) begin
			pdat_ff <= nxt_pdat;
			pdir_ff <= nxt_pdir;
		end
	end

	assign port_pin_o  = pdat_ff;
	assign port_pin_oe = pdir_ff;

	//----------------------------------------
	// Checks
	//----------------------------------------
	chk_trap_halt_exc: assert property (@(posedge clk) disable iff (rst)
		clk_en && st_ff == ST_HALT && trap_ff |=> halt_exc_start && !power_down)
		else $error("halt exception not started with trap enabled");
	chk_notrap_down: assert property (@(posedge clk) disable iff (rst)
		clk_en && st_ff == ST_HALT && !trap_ff |=> power_down && !halt_exc_start)
		else $error("halt did not enter power-down");
	chk_cancel_wake: assert property (@(posedge clk) disable iff (rst)
		clk_en && st_ff == ST_DOWN && cancel_req ##1 clk_en |=> cancel_exc_start)
		else $error("cancel did not wake and start exception");
	chk_down_holds: assert property (@(posedge clk) disable iff (rst)
		power_down && clk_en && !cancel_req |=> power_down)
		else $error("power-down left without cancel");
	chk_reset_trap: assert property (@(posedge clk)
		$fell(rst) |-> !halt_trap_enable)
		else $error("trap enable not clear after reset");
	chk_dir_hiz: assert property (@(posedge clk) disable iff (rst)
		clk_en && !pin_dir |=> !clk_pin_oe)
		else $error("clock pin driven with direction 0");
	chk_stop_high: assert property (@(posedge clk) disable iff (rst)
		stopped_ff && clk_en |=> clk_pin_o)
		else $error("stopped clock output not high");
	chk_hw_standby: assert property (@(posedge clk) disable iff (rst)
		clk_en && hw_standby |=> !clk_pin_oe && port_pin_oe == '0)
		else $error("pins driven in hardware standby");
	chk_port_hold: assert property (@(posedge clk) disable iff (rst)
		clk_en && sw_standby |=> $stable(port_pin_o))
		else $error("port data changed in software standby");

	// Sequencing: halt is taken in the run state, a cancel raised with it is serviced first
	chk_halt_taken: assert property (@(posedge clk) disable iff (rst)
		clk_en && st_ff == ST_RUN && halt_exec |=> st_ff == ST_HALT)
		else $error("halt instruction not taken in run state");
	chk_notrap_no_exc: assert property (@(posedge clk) disable iff (rst)
		clk_en && !trap_ff |=> !halt_exc_start)
		else $error("halt exception started with trap disabled");
	chk_trap_write: assert property (@(posedge clk) disable iff (rst)
		clk_en && trap_en_wr |=> halt_trap_enable == $past(trap_en_wdata))
		else $error("trap enable write not applied");
	chk_cancel_first: assert property (@(posedge clk) disable iff (rst)
		clk_en && st_ff == ST_RUN && halt_exec && cancel_req && trap_ff && !trap_en_wr
		##1 clk_en |-> cancel_exc_start ##1 (halt_exc_start && !power_down))
		else $error("cancel before halt not followed by halt exception");

	// Clock pin: follows the bus clock, forced high when stopped, prohibited or in software standby
	chk_clk_follow: assert property (@(posedge clk) disable iff (rst)
		clk_en && pin_dir && !hw_standby && !sw_standby && !clock_out_stop
		&& !clock_out_select && !stopped_ff
		|=> clk_pin_oe && clk_pin_o == $past(bus_clk_level))
		else $error("clock pin does not follow the bus clock");
	chk_bad_setting: assert property (@(posedge clk) disable iff (rst)
		clk_en && pin_dir && !clock_out_stop && clock_out_select
		|=> clk_setting_bad && clk_pin_o)
		else $error("prohibited clock setting not flagged");
	chk_stop_boundary: assert property (@(posedge clk) disable iff (rst)
		clk_en && clock_out_stop && bus_cycle_end ##1 clk_en |=> clk_pin_o)
		else $error("clock output not high after stop at cycle end");
	chk_standby_high: assert property (@(posedge clk) disable iff (rst)
		clk_en && sw_standby |=> clk_pin_o)
		else $error("clock pin not high in software standby");
endmodule

// File: rtl/halt_trap_consts.svh
`ifndef HALT_TRAP_CONSTS_SVH
`define HALT_TRAP_CONSTS_SVH

//----------------------------------------
// Reset values and port width
//----------------------------------------
`define HALT_TRAP_ENABLE_RST 1'b0
`define PORT_WIDTH           8
`define PORT_RST             8'h00
`define FLAG_RST             1'b0
`define CLK_PIN_HIGH         1'b1
`endif

// File: rtl/halt_trap_pkg.sv
package halt_trap_pkg;
	// Gray coded along run -> halt decode -> power-down -> wake
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_HALT  = 2'b01,
		ST_DOWN  = 2'b11,
		ST_WAKE  = 2'b10
	} cpu_state_e;
endpackage

// File: tb/halt_trap_and_clock_out_ctrl_tb.sv
`timescale 1ns/1ps
`include "halt_trap_consts.svh"
module halt_trap_and_clock_out_ctrl_tb
	import halt_trap_pkg::*;
;
	logic                   clk = 1'b0;
	logic                   rst, clk_en, halt_exec, cancel_req, trap_en_wr, trap_en_wdata;
	logic                   clock_out_stop, clock_out_select, pin_dir, bus_cycle_end;
	logic                   bus_clk_level, sw_standby, hw_standby;
	logic [`PORT_WIDTH-1:0] port_out, port_dir, port_pin_o, port_pin_oe;
	logic                   halt_trap_enable, power_down, halt_exc_start, cancel_exc_start;
	logic                   clk_pin_o, clk_pin_oe, clk_setting_bad;
	logic [7:0]             n_halt = 8'h00;
	logic [7:0]             n_cancel = 8'h00;
	int                     n_mismatch = 0;
	int                     checked = 0;

	halt_trap_and_clock_out_ctrl dut (.clk, .rst, .clk_en, .halt_exec, .cancel_req, .trap_en_wr,
		.trap_en_wdata, .clock_out_stop, .clock_out_select, .pin_dir, .bus_cycle_end,
		.bus_clk_level, .sw_standby, .hw_standby, .port_out, .port_dir, .halt_trap_enable,
		.power_down, .halt_exc_start, .cancel_exc_start, .clk_pin_o, .clk_pin_oe,
		.clk_setting_bad, .port_pin_o, .port_pin_oe);

	// 100 MHz clock
	always #5 clk = ~clk;

	// Count exception pulses so overlapping events can be judged by number, not timing
	always @(posedge clk) begin
		if (clk_en && halt_exc_start === 1'b1) n_halt <= n_halt + 8'h01;
		if (clk_en && cancel_exc_start === 1'b1) n_cancel <= n_cancel + 8'h01;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Halt and cancel may be raised together to model a cancel just before halt
	task events(input logic h, input logic c);
		halt_exec = h;
		cancel_req = c;
		tick(1);
		halt_exec = 1'b0;
		cancel_req = 1'b0;
		tick(2);
	endtask

	task trap_wr(input logic v);
		trap_en_wr = 1'b1;
		trap_en_wdata = v;
		tick(1);
		trap_en_wr = 1'b0;
		tick(1);
	endtask

	task end_of_test;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{halt_exec, cancel_req, trap_en_wr, trap_en_wdata, clock_out_stop} = 5'h00;
		{clock_out_select, pin_dir, bus_cycle_end, bus_clk_level, sw_standby, hw_standby} = 6'h00;
		{port_out, port_dir} = 16'h0000;
		clk_en = 1'b1;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk(halt_trap_enable, 8'h00);
		chk(clk_pin_oe, 8'h00);
		events(1'b1, 1'b0);
		chk({halt_exc_start, power_down}, 8'h01);
		tick(3);
		chk(power_down, 8'h01);
		events(1'b0, 1'b1);
		chk({power_down, n_cancel}, 8'h01);
		events(1'b1, 1'b1);
		tick(3);
		chk({power_down, n_cancel}, {1'b1, 8'h02});
		events(1'b0, 1'b1);
		trap_wr(1'b1);
		chk(halt_trap_enable, 8'h01);
		events(1'b1, 1'b0);
		chk({power_down, n_halt}, {1'b0, 8'h01});
		events(1'b1, 1'b1);
		tick(3);
		chk({power_down, n_cancel[3:0], n_halt[3:0]}, {1'b0, 4'h4, 4'h2});
		trap_wr(1'b0);
		// Clock pin: running, then stopped at the end of a bus cycle
		pin_dir = 1'b1;
		for (int v = 0; v < 2; v++) begin
			bus_clk_level = v[0];
			tick(2);
			chk({clk_pin_oe, clk_pin_o}, {1'b1, v[0]});
		end
		clock_out_stop = 1'b1;
		bus_clk_level = 1'b0;
		tick(2);
		chk(clk_pin_o, 8'h00);
		bus_cycle_end = 1'b1;
		tick(1);
		bus_cycle_end = 1'b0;
		tick(2);
		chk({clk_pin_oe, clk_pin_o}, 8'h03);
		clock_out_stop = 1'b0;
		clock_out_select = 1'b1;
		tick(2);
		chk({clk_setting_bad, clk_pin_o}, 8'h03);
		clock_out_select = 1'b0;
		// Standby: port state frozen, clock pin high, then released in hardware standby
		port_out = 8'ha5;
		port_dir = 8'hf0;
		tick(2);
		chk(port_pin_o, 8'ha5);
		sw_standby = 1'b1;
		port_out = 8'h5a;
		port_dir = 8'h0f;
		tick(2);
		chk(port_pin_o, 8'ha5);
		chk(port_pin_oe, 8'hf0);
		chk({clk_pin_oe, clk_pin_o}, 8'h03);
		hw_standby = 1'b1;
		tick(2);
		chk({port_pin_oe, clk_pin_oe}, 8'h00);
		pin_dir = 1'b0;
		tick(2);
		chk(clk_pin_oe, 8'h00);
		// Clock enable low: halt, cancel and the standby release are all held off
		{sw_standby, hw_standby} = 2'h0;
		clk_en = 1'b0;
		events(1'b1, 1'b1);
		clk_en = 1'b1;
		chk({power_down, n_cancel[3:0], n_halt[3:0]}, {1'b0, 4'h4, 4'h2});
		chk({port_pin_oe, port_pin_o}, 16'h00a5);
		// Mid-run reset clears a set trap enable; module stop is never requested here
		trap_wr(1'b1);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk(halt_trap_enable, 8'h00);
		events(1'b1, 1'b0);
		chk(power_down, 8'h01);
		end_of_test;
	end
endmodule
